/* File: design/ubf_host.v */
// Summary of operation
// (RL1) Device holds tx_not_ready_n high when its transmit buffer is full or busy.
// (RL2) Controller never lowers the write strobe while tx_not_ready_n is high.
// (RL3) Device drives rx_data_avail_n low while receive bytes wait to be read.
// (RL4) Device raises rx_data_avail_n once its receive buffer is empty.
// (RL5) Device takes the data bus byte on the write strobe falling edge.
// (RL6) Device forwards each accepted byte to the USB host without a flush.
// (RL7) Device drives the data bus only while the read strobe is low; ubf_dev_model drives the inverted head byte at other times.
// (RL8) Read strobe rising releases the bus and pops the byte read.
// (RL9) Device resets all state while external_reset_n is held low.
// (RL10) Device drives the suspend output low while in USB suspend.
// (RL11) Controller holds each read strobe low at least 50 ns.
// (RL12) Controller holds the read strobe high at least 50 ns between reads.
// (RL13) Device keeps rx_data_avail_n high at least 80 ns after each read.
// (RL14) Controller holds each write strobe active at least 50 ns.
// (RL15) Controller holds the write strobe inactive at least 50 ns between writes.
// (RL16) Device keeps tx_not_ready_n high at least 80 ns after each write.
// (RL17) Device ignores baud rate settings and runs at its fastest rate.
// (RL18) Bytes travel on an eight-bit two-way bus, bit zero least significant.
// (RL19) Asynchronous strobes and flags pass two flip-flops before any logic.
`timescale 1ns/10ps
`default_nettype none
`include "ubf_host_map.vh"

module ubf_host (
	// Clock and reset
	input  wire                    clock_in,
	input  wire                    rst_in,
	// User write request
	input  wire                    wr_req_in,
	input  wire [`UBF_DATA_W-1:0]  wr_data_in,
	output wire                    wr_ready_out,
	// User read request and answer
	input  wire                    rd_req_in,
	output wire                    rd_ready_out,
	output reg  [`UBF_DATA_W-1:0]  rd_data_ff_out,
	output reg                     rd_valid_ff_out,
	// Device status pins
	input  wire                    tx_not_ready_n_in,
	input  wire                    rx_data_avail_n_in,
	input  wire                    sleep_n_in,
	output wire                    suspended_out,
	// Device strobes and reset
	output wire                    wr_strobe_out,
	output wire                    rd_strobe_n_out,
	output wire                    external_reset_n_out,
	// Two-way data bus
	input  wire [`UBF_DATA_W-1:0]  data_bus_in,
	output wire [`UBF_DATA_W-1:0]  data_bus_out,
	output wire [`UBF_DATA_W-1:0]  data_bus_oe_out
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	reg [2:0]              meta_ff;
	reg [2:0]              sync_ff;
	reg [`UBF_DATA_W-1:0]  bus_meta_ff;
	reg [`UBF_DATA_W-1:0]  bus_sync_ff;

	// Two stages for flags and data bus
	always @(posedge clock_in) begin
		if (rst_in) begin
			meta_ff     <= 3'h7;
			sync_ff     <= 3'h7;
			bus_meta_ff <= 8'h00;
			bus_sync_ff <= 8'h00;
		end else begin
			meta_ff     <= {sleep_n_in, rx_data_avail_n_in, tx_not_ready_n_in}; // RL19
			sync_ff     <= meta_ff;
			bus_meta_ff <= data_bus_in;
			bus_sync_ff <= bus_meta_ff;
		end
	end

	wire tx_busy_s   = sync_ff[0];
	wire rx_empty_s  = sync_ff[1];
	wire sleep_n_s   = sync_ff[2];

	// ****************************************
	// Strobe sequencer
	// ****************************************
	reg [2:0]              state_ff;
	reg [2:0]              nxt_state;
	reg [`UBF_CNT_W-1:0]   cnt_ff;
	reg [`UBF_CNT_W-1:0]   nxt_cnt;
	reg [`UBF_DATA_W-1:0]  wdata_ff;
	reg [`UBF_DATA_W-1:0]  nxt_wdata;
	reg                    wr_ff;
	reg                    nxt_wr;
	reg                    rd_n_ff;
	reg                    nxt_rd_n;
	reg                    oe_ff;
	reg                    nxt_oe;
	reg [`UBF_DATA_W-1:0]  nxt_rd_data;
	reg                    nxt_rd_valid;

	wire idle_w = (state_ff == `UBF_ST_IDLE);

	// Counter loads; read adds bus settle and sync time, recovery lets flags settle
	localparam [31:0] WR_LOW_N  = `UBF_WR_LOW_CYC;
	localparam [31:0] WR_HIGH_N = `UBF_WR_HIGH_CYC + `UBF_RECOVER_CYC;
	localparam [31:0] RD_LOW_N  = `UBF_RD_LOW_CYC + `UBF_RD_DATA_CYC + `UBF_SYNC_CYC;
	localparam [31:0] RD_HIGH_N = `UBF_RD_HIGH_CYC + `UBF_RECOVER_CYC;

	// Write has priority; both need idle and a ready device
	assign wr_ready_out = idle_w && !tx_busy_s; // RL2
	assign rd_ready_out = idle_w && !rx_empty_s && !wr_req_in; // RL3

	// Next state and strobe levels
	always @* begin
		nxt_state    = state_ff;
		nxt_cnt      = cnt_ff;
		nxt_wdata    = wdata_ff;
		nxt_wr       = wr_ff;
		nxt_rd_n     = rd_n_ff;
		nxt_oe       = oe_ff;
		nxt_rd_data  = rd_data_ff_out;
		nxt_rd_valid = 1'b0;
		case (state_ff)
			`UBF_ST_IDLE: begin
				if (wr_req_in && !tx_busy_s) begin
					// Data goes out a cycle before the strobe falls
					nxt_wdata = wr_data_in;
					nxt_oe    = 1'b1;
					nxt_state = `UBF_ST_WR_SETUP; // RL2
				end else if (rd_req_in && !rx_empty_s) begin
					nxt_rd_n  = 1'b0; // RL7
					nxt_cnt   = RD_LOW_N[`UBF_CNT_W-1:0];
					nxt_state = `UBF_ST_RD_LOW;
				end
			end
			`UBF_ST_WR_SETUP: begin
				// Bus has settled; device takes the byte on this fall
				nxt_wr    = 1'b0; // RL5
				nxt_cnt   = WR_LOW_N[`UBF_CNT_W-1:0];
				nxt_state = `UBF_ST_WR_LOW;
			end
			`UBF_ST_WR_LOW: begin
				if (cnt_ff > 1) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_wr    = 1'b1; // RL14
					nxt_cnt   = WR_HIGH_N[`UBF_CNT_W-1:0];
					nxt_state = `UBF_ST_WR_HIGH;
				end
			end
			`UBF_ST_WR_HIGH: begin
				// Data held two cycles past strobe rise, then bus released
				if (cnt_ff != WR_HIGH_N[`UBF_CNT_W-1:0]) begin
					nxt_oe = 1'b0;
				end
				if (cnt_ff > 1) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_state = `UBF_ST_IDLE; // RL15 RL16
				end
			end
			`UBF_ST_RD_LOW: begin
				if (cnt_ff > 1) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					// Synced bus sample is stable by now
					nxt_rd_data  = bus_sync_ff; // RL18
					nxt_rd_valid = 1'b1;
					nxt_rd_n     = 1'b1; // RL8 RL11
					nxt_cnt      = RD_HIGH_N[`UBF_CNT_W-1:0];
					nxt_state    = `UBF_ST_RD_HIGH;
				end
			end
			`UBF_ST_RD_HIGH: begin
				// Wait lets the flag settle before next read
				if (cnt_ff > 1) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_state = `UBF_ST_IDLE; // RL12 RL13
				end
			end
			default: begin
				nxt_state = `UBF_ST_IDLE;
				nxt_wr    = 1'b1;
				nxt_rd_n  = 1'b1;
				nxt_oe    = 1'b0;
			end
		endcase
	end

	// State registers
	always @(posedge clock_in) begin
		if (rst_in) begin
			state_ff        <= `UBF_ST_IDLE;
			cnt_ff          <= {`UBF_CNT_W{1'b0}};
			wdata_ff        <= 8'h00;
			wr_ff           <= 1'b1;
			rd_n_ff         <= 1'b1;
			oe_ff           <= 1'b0;
			rd_data_ff_out  <= 8'h00;
			rd_valid_ff_out <= 1'b0;
		end else begin
			state_ff        <= nxt_state;
			cnt_ff          <= nxt_cnt;
			wdata_ff        <= nxt_wdata;
			wr_ff           <= nxt_wr;
			rd_n_ff         <= nxt_rd_n;
			oe_ff           <= nxt_oe;
			rd_data_ff_out  <= nxt_rd_data;
			rd_valid_ff_out <= nxt_rd_valid;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	// Device reset follows our reset
	assign external_reset_n_out = !rst_in; // RL9
	assign wr_strobe_out        = wr_ff;
	assign rd_strobe_n_out      = rd_n_ff;
	assign data_bus_out         = wdata_ff;
	assign data_bus_oe_out      = {`UBF_DATA_W{oe_ff}};
	assign suspended_out        = !sleep_n_s; // RL10

endmodule // ubf_host

`default_nettype wire

/* File: design/ubf_host_map.vh */
`ifndef UBF_HOST_MAP_VH
`define UBF_HOST_MAP_VH

// ****************************************
// Clock and link timing
// ****************************************
`define UBF_CLK_PERIOD_NS     5
`define UBF_RD_LOW_NS         50
`define UBF_RD_HIGH_NS        50
`define UBF_WR_LOW_NS         50
`define UBF_WR_HIGH_NS        50
`define UBF_RD_DATA_NS        30
`define UBF_RD_LOW_CYC        ((`UBF_RD_LOW_NS + `UBF_CLK_PERIOD_NS - 1) / `UBF_CLK_PERIOD_NS)
`define UBF_RD_HIGH_CYC       ((`UBF_RD_HIGH_NS + `UBF_CLK_PERIOD_NS - 1) / `UBF_CLK_PERIOD_NS)
`define UBF_WR_LOW_CYC        ((`UBF_WR_LOW_NS + `UBF_CLK_PERIOD_NS - 1) / `UBF_CLK_PERIOD_NS)
`define UBF_WR_HIGH_CYC       ((`UBF_WR_HIGH_NS + `UBF_CLK_PERIOD_NS - 1) / `UBF_CLK_PERIOD_NS)
`define UBF_RD_DATA_CYC       ((`UBF_RD_DATA_NS + `UBF_CLK_PERIOD_NS - 1) / `UBF_CLK_PERIOD_NS)
`define UBF_SYNC_CYC          2
`define UBF_RECOVER_CYC       3

// ****************************************
// Bus layout and states
// ****************************************
`define UBF_DATA_W            8
`define UBF_CNT_W             5
`define UBF_ST_IDLE           3'h0
`define UBF_ST_WR_LOW         3'h1
`define UBF_ST_WR_HIGH        3'h2
`define UBF_ST_RD_LOW         3'h3
`define UBF_ST_RD_HIGH        3'h4
`define UBF_ST_WR_SETUP       3'h5

`endif

/* File: verification/ubf_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ubf_dev_model (
	input  wire logic       wr_in, rd_n_in, rst_n_in,
	input  wire logic [7:0] d_in,
	output var  logic       tx_not_ready_n_out, rx_data_avail_n_out,
	output wire logic [7:0] d_out);
	logic [7:0] rxq[$], sent[$], head;
	logic       drv = 0;
	// Head byte while read low, inverse once released
	assign d_out = drv ? head : ~head;
	// Reset clears buffers and flags
	always @(rst_n_in) begin
		tx_not_ready_n_out = !rst_n_in;
		rx_data_avail_n_out = 1;
		rxq = {};
		sent = {};
	end
	// Take byte on falling strobe, forward at once
	always @(negedge wr_in) if (rst_n_in) begin
		sent.push_back(d_in);
		tx_not_ready_n_out = 1;
		#80 tx_not_ready_n_out = 0;
	end
	// Present head byte
	always @(negedge rd_n_in) if (rst_n_in && rxq.size() > 0) begin
		head = rxq[0];
		drv = 1;
	end
	// Release, pop, hold flag off
	always @(posedge rd_n_in) if (drv) begin
		drv = 0;
		void'(rxq.pop_front());
		rx_data_avail_n_out = 1;
		#80 rx_data_avail_n_out = (rxq.size() == 0);
	end
	task push(input logic [7:0] b);
		rxq.push_back(b);
		rx_data_avail_n_out = 0;
	endtask
endmodule // ubf_dev_model
`default_nettype wire

/* File: verification/ubf_host_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ubf_host_props (
	input wire logic       clock_in, rst_in, wr_strobe_out, rd_strobe_n_out, tx_not_ready_n_in,
	input wire logic       sleep_n_in, suspended_out, rd_valid_ff_out,
	input wire logic [7:0] data_bus_oe_out);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	no_wr_busy_a: assert property ($fell(wr_strobe_out) |-> !$past(tx_not_ready_n_in, 4)) else $error("busy");
	wr_low_a: assert property ($fell(wr_strobe_out) |-> (!wr_strobe_out)[*8] ##1 (!wr_strobe_out)[*2]) else $error("wl");
	wr_high_a: assert property ($rose(wr_strobe_out) |-> wr_strobe_out[*8] ##1 wr_strobe_out[*2]) else $error("wh");
	rd_low_a: assert property ($fell(rd_strobe_n_out) |-> (!rd_strobe_n_out)[*8] ##1 (!rd_strobe_n_out)[*2]) else $error("rl");
	rd_high_a: assert property ($rose(rd_strobe_n_out) |-> rd_strobe_n_out[*8] ##1 rd_strobe_n_out[*2]) else $error("rh");
	no_clash_a: assert property (!rd_strobe_n_out |-> data_bus_oe_out == 8'h00) else $error("clash");
	rd_pulse_a: assert property ($rose(rd_strobe_n_out) |-> rd_valid_ff_out ##1 !rd_valid_ff_out) else $error("rv");
	susp_on_a: assert property ($fell(sleep_n_in) |-> ##[1:5] suspended_out) else $error("susp");
endmodule // ubf_host_props
bind ubf_host ubf_host_props u_ubf_host_props (.clock_in(clock_in), .rst_in(rst_in), .wr_strobe_out(wr_strobe_out),
	.rd_strobe_n_out(rd_strobe_n_out), .tx_not_ready_n_in(tx_not_ready_n_in), .sleep_n_in(sleep_n_in),
	.suspended_out(suspended_out), .rd_valid_ff_out(rd_valid_ff_out), .data_bus_oe_out(data_bus_oe_out));
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic       clk = 0, rst = 1, wr_req = 0, rd_req = 0, sleep_n = 1;
	logic [7:0] wr_data = 8'h00, rd_data, des_d, des_oe, dev_d;
	logic       wr_rdy, rd_rdy, rd_vld, susp, wr_s, rd_s_n, ext_n, tx_nrdy_n, rx_avail_n;
	wire  [7:0] bus = des_oe[0] ? des_d : dev_d;
	integer     fails = 0, n_checks = 0;
	initial forever #2.5 clk = ~clk;
	ubf_host u_ubf_host (.clock_in(clk), .rst_in(rst), .wr_req_in(wr_req), .wr_data_in(wr_data),
		.wr_ready_out(wr_rdy), .rd_req_in(rd_req), .rd_ready_out(rd_rdy), .rd_data_ff_out(rd_data),
		.rd_valid_ff_out(rd_vld), .tx_not_ready_n_in(tx_nrdy_n), .rx_data_avail_n_in(rx_avail_n),
		.sleep_n_in(sleep_n), .suspended_out(susp), .wr_strobe_out(wr_s), .rd_strobe_n_out(rd_s_n),
		.external_reset_n_out(ext_n), .data_bus_in(bus), .data_bus_out(des_d), .data_bus_oe_out(des_oe));
	ubf_dev_model u_ubf_dev_model (.wr_in(wr_s), .rd_n_in(rd_s_n), .rst_n_in(ext_n), .d_in(bus),
		.tx_not_ready_n_out(tx_nrdy_n), .rx_data_avail_n_out(rx_avail_n), .d_out(dev_d));
	task chk(input string n, input logic [7:0] e, s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task t_write(input logic [7:0] a, b);
		for (int i = 0; i < 2; i++) begin
			repeat (40) if (wr_rdy !== 1) @(negedge clk);
			wr_req = 1;
			wr_data = i ? b : a;
			@(negedge clk);
			wr_req = 0;
		end
		repeat (40) @(negedge clk);
		chk("sent0", a, u_ubf_dev_model.sent[0]);
		chk("sent1", b, u_ubf_dev_model.sent[1]);
	endtask
	task t_read(input logic [7:0] a, b);
		u_ubf_dev_model.push(a);
		u_ubf_dev_model.push(b);
		for (int i = 0; i < 2; i++) begin
			repeat (60) if (rd_rdy !== 1) @(negedge clk);
			rd_req = 1;
			@(negedge clk);
			rd_req = 0;
			repeat (40) if (rd_vld !== 1) @(negedge clk);
			chk("rd_data", i ? b : a, rd_data);
		end
		repeat (40) @(negedge clk);
		chk("rd_ready", 8'h00, {7'h0, rd_rdy});
	endtask
	task t_suspend;
		sleep_n = 0;
		repeat (6) @(negedge clk);
		chk("susp_on", 8'h01, {7'h0, susp});
		sleep_n = 1;
		repeat (6) @(negedge clk);
		chk("susp_off", 8'h00, {7'h0, susp});
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		test_done;
	end
	initial begin
		repeat (8) @(negedge clk);
		chk("ext_rst_n", 8'h00, {7'h0, ext_n});
		rst = 0;
		t_write(8'h01, 8'h80);
		t_read(8'ha5, 8'h3c);
		t_suspend;
		test_done;
	end
endmodule // tb
`default_nettype wire
